// ===== rtl/lcdbc_pkg.sv
// constants, carriers and state type of the led cluster dimming/boost control
package lcdbc_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_BRT1  = 8'h04;
  localparam logic [7:0] OFS_BRT2  = 8'h08;
  localparam logic [7:0] OFS_BRT3  = 8'h0c;
  localparam logic [7:0] OFS_BRT4  = 8'h10;
  localparam logic [7:0] OFS_CUR1  = 8'h14;
  localparam logic [7:0] OFS_CUR2  = 8'h18;
  localparam logic [7:0] OFS_CUR3  = 8'h1c;
  localparam logic [7:0] OFS_CUR4  = 8'h20;
  localparam logic [7:0] OFS_TRIM  = 8'h24;
  localparam logic [7:0] OFS_BOOST = 8'h28;
  localparam logic [7:0] OFS_STAT  = 8'h2c;
  // control field positions
  localparam int CTL_CLUSTER = 0;  // 4 bits, one per string
  localparam int CTL_FLTEN   = 4;
  localparam int CTL_ADAP    = 5;
  localparam int CTL_SPREAD  = 6;
  localparam int CTL_GDSEL   = 7;
  localparam int CTL_PUMPON  = 8;
  localparam int CTL_RES     = 9;  // 2 bits
  localparam int CTL_PUMPCLK = 11; // 2 bits
  localparam int CTL_NCH     = 13;
  localparam int CTL_SHDN    = 14;
  localparam int CTRL_W      = 15;
  localparam int STAT_RANGE  = 16; // position of range field in trim reg
  localparam int BOOST_FREQ  = 6;  // position of freq field in boost reg
  // reset values
  localparam logic [14:0] CTRL_RST  = 15'h0000;
  localparam logic [15:0] TRIM_RST  = 16'h7777;
  localparam logic [8:0]  BOOST_RST = 9'h020;
  // timing
  localparam int unsigned PWM_BITS    = 13;
  localparam int unsigned SYNC_MIN_NS = 200;
  localparam int unsigned SYNC_MIN_CYC =
    (SYNC_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SYNC_TOL_PCT = 25;
  localparam int unsigned SPREAD_PCT   = 3;
  localparam int unsigned SPREAD_MHZ   = 1_875_000; // modulation, mHz
  localparam int unsigned SPREAD_HALF  =
    int'(64'(CLK_HZ) * 1000 / (2 * 64'(SPREAD_MHZ)));
  localparam int unsigned ADAPT_CYC    = 64;
  // boost internal period per freq select, cycles
  localparam logic [15:0] BST_PER [8] = '{
    16'(CLK_HZ / 100_000),   16'(CLK_HZ / 200_000),
    16'(CLK_HZ / 300_000),   16'(CLK_HZ / 400_000),
    16'(CLK_HZ / 600_000),   16'(CLK_HZ / 800_000),
    16'(CLK_HZ / 1_200_000), 16'(CLK_HZ / 2_200_000)};
  // pump clock half periods for 104/208/417/833 kHz
  localparam logic [7:0] PUMP_HALF [4] = '{
    8'(CLK_HZ / (2 * 104_000)), 8'(CLK_HZ / (2 * 208_000)),
    8'(CLK_HZ / (2 * 417_000)), 8'(CLK_HZ / (2 * 833_000))};
  // trim correction in 0.1 % units, signed
  localparam logic [7:0] TRIM_CORR [16] = '{
    8'h41, 8'h38, 8'h2f, 8'h25, 8'h1c, 8'h13, 8'h09, 8'h00,
    8'hf7, 8'hed, 8'he4, 8'hdb, 8'hd1, 8'hc8, 8'hbf, 8'hb6};

  typedef enum logic [2:0] {
    LS_OFF = 3'b001, LS_ON = 3'b010, LS_RECOVER = 3'b100
  } lcdbc_ls_t;

  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid;
    logic [31:0] wdata; logic [3:0] wstrb; logic bready;
    logic arvalid; logic [7:0] araddr; logic rready;
  } lcdbc_axi_in_t;

  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } lcdbc_axi_out_t;

  typedef struct packed {
    logic [14:0] ctrl; logic [15:0] brt1; logic [12:0] brt2, brt3, brt4;
    logic [11:0] cur1; logic [7:0] cur2, cur3, cur4; logic [15:0] trim;
    logic [2:0] range; logic [8:0] boost; logic [4:0] sticky;
    logic loaded; logic bvalid; logic [1:0] bresp; logic rvalid;
    logic [31:0] rdata; logic [1:0] rresp; logic [1:0] div;
    logic [12:0] pwmCnt; logic [3:0] pwmOut; logic [31:0] trimOut;
    logic [7:0] target; logic rampDone; logic [7:0] adaptCnt;
    logic syncPrev; logic [15:0] syncW, syncP; logic wOk; logic syncLock;
    logic [15:0] bstCnt; logic bstTick; logic [15:0] sprCnt;
    logic sprSign; logic [7:0] pumpCnt; logic pumpClk; lcdbc_ls_t ls;
  } lcdbc_state_t;

  localparam lcdbc_state_t ST_RST = '{ctrl: CTRL_RST, trim: TRIM_RST,
    boost: BOOST_RST, ls: LS_OFF, default: '0};
endpackage

// ===== rtl/lcdbc_top.sv
// led cluster dimming, boost setting, pump clock and line switch control
`timescale 1ns/1ps
// Behaviour
// R01: four-bit trim code maps to current correction, +6.5 % down to -7.4 %.
// R02: string one current and max range load from nonvolatile copies at start.
// R03: power-on reset clears string two and three current levels to zero.
// R04: host never writes zero current while that string's brightness is nonzero.
// R05: each cluster string has its own current level and its own duty.
// R06: cluster strings use register PWM only; pin and smoothing paths ignored.
// R07: string one duty uses upper 13 of 16 brightness bits in cluster mode.
// R08: all strings clustered gives 13-bit resolution, period from 2-bit field.
// R09: field codes 0..3 pick 5/10/20/40 MHz, 610..4883 Hz PWM; code 3 runs at 20 MHz, 2441 Hz, here.
// R10: with any display string, cluster strings follow display PWM timing.
// R11: cluster string headroom above high or below low level raises fault.
// R12: adaptive boost looks only at display-mode strings' headroom.
// R13: all strings clustered holds boost target at start-voltage setting.
// R14: fault-detect enable low suppresses cluster led fault detection.
// R15: cluster strings disable temperature derating and sensor limiting.
// R16: adaptive mode ramps to start voltage, then steps 125 mV by headroom.
// R17: boost follows sync 100 kHz-2.2 MHz within 25 %, else internal rate.
// R18: spread spectrum moves boost period 3 % at 1.875 kHz.
// R19: host sets gate-drive supply select before enabling the pump; the host model sets both in the same write.
// R20: pump clock field selects 104, 208, 417 or 833 kHz.
// R21: any fault opens line switch then recovery; switch off in shutdown.
// R22: input overcurrent opens line switch and sets its flag.
// R23: cluster output high for brightness count cycles of each 8192.
module lcdbc_top #(
  parameter int unsigned SPREAD_HALF_CYC = lcdbc_pkg::SPREAD_HALF
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire lcdbc_pkg::lcdbc_axi_in_t axiIn,
  output lcdbc_pkg::lcdbc_axi_out_t     axiOut,
  input  wire logic [11:0]              nvCurrentDefault,
  input  wire logic [2:0]               nvMaxCurrentRange,
  input  wire logic [3:0]               displayPwm,
  input  wire logic                     displayTick,
  input  wire logic [3:0]               displayResBits,
  input  wire logic [3:0]               headroomHigh,
  input  wire logic [3:0]               headroomLow,
  input  wire logic                     inputOvercurrent,
  input  wire logic                     otherFault,
  input  wire logic                     syncIn,
  output logic [3:0]                    pwmOut,
  output logic [31:0]                   trimCorrection,
  output logic [11:0]                   stringOneCurrentLevel,
  output logic [23:0]                   stringCurrentLevels,
  output logic [2:0]                    maxCurrentRange,
  output logic [3:0]                    derateEnable,
  output logic [7:0]                    boostTarget,
  output logic                          boostTick,
  output logic                          pumpClk,
  output logic                          lineSwitchOn,
  output logic                          nchannelLineSwitch
);
  lcdbc_pkg::lcdbc_state_t st_q, st_d;
  logic [3:0]  cluster;
  logic        allCluster;
  logic        fltEn;
  logic [3:0]  fltEvt;
  logic        anyFault;
  logic        wrGo, rdGo, wrOk, rdOk;
  logic [31:0] wMask, rdVal, statVal;
  logic [3:0]  res;
  logic [12:0] pwmMask;
  logic [12:0] duty [4];
  logic [15:0] basePer, dev, effPer, tolLo, tolHi;
  logic        syncRise, syncGood, dispLow, dispAllHigh;
  logic [7:0]  startTgt;

  assign cluster    = st_q.ctrl[lcdbc_pkg::CTL_CLUSTER +: 4];
  assign allCluster = &cluster;
  assign fltEn      = st_q.ctrl[lcdbc_pkg::CTL_FLTEN];
  // cluster headroom window faults, gated by enable
  assign fltEvt = {4{fltEn}} & cluster & (headroomHigh | headroomLow); // [R11] [R14]
  assign anyFault = inputOvercurrent | otherFault | (|fltEvt);
  assign startTgt = {st_q.boost[5:0], 2'b00}; // target counts 125 mV steps

  // ready outputs combinational; valid, response and data from flops
  assign wrGo = axiIn.awvalid & axiIn.wvalid & ~st_q.bvalid;
  assign rdGo = axiIn.arvalid & ~st_q.rvalid;
  assign axiOut = '{awready: wrGo, wready: wrGo, bvalid: st_q.bvalid,
    bresp: st_q.bresp, arready: rdGo, rvalid: st_q.rvalid,
    rdata: st_q.rdata, rresp: st_q.rresp};
  assign wMask = {{8{axiIn.wstrb[3]}}, {8{axiIn.wstrb[2]}},
                  {8{axiIn.wstrb[1]}}, {8{axiIn.wstrb[0]}}};
  assign statVal = {16'h0000, st_q.target, 1'b0,
                    st_q.ls == lcdbc_pkg::LS_RECOVER, st_q.syncLock,
                    st_q.sticky};

  // read decode; unmapped answers slverr with zero data
  always_comb
  begin
    rdOk  = 1'b1;
    rdVal = 32'h0000_0000;
    case (axiIn.araddr)
      lcdbc_pkg::OFS_CTRL:  rdVal = {17'h00000, st_q.ctrl};
      lcdbc_pkg::OFS_BRT1:  rdVal = {16'h0000, st_q.brt1};
      lcdbc_pkg::OFS_BRT2:  rdVal = {19'h00000, st_q.brt2};
      lcdbc_pkg::OFS_BRT3:  rdVal = {19'h00000, st_q.brt3};
      lcdbc_pkg::OFS_BRT4:  rdVal = {19'h00000, st_q.brt4};
      lcdbc_pkg::OFS_CUR1:  rdVal = {20'h00000, st_q.cur1};
      lcdbc_pkg::OFS_CUR2:  rdVal = {24'h000000, st_q.cur2};
      lcdbc_pkg::OFS_CUR3:  rdVal = {24'h000000, st_q.cur3};
      lcdbc_pkg::OFS_CUR4:  rdVal = {24'h000000, st_q.cur4};
      lcdbc_pkg::OFS_TRIM:  rdVal = {13'h0000, st_q.range, st_q.trim};
      lcdbc_pkg::OFS_BOOST: rdVal = {23'h000000, st_q.boost};
      lcdbc_pkg::OFS_STAT:  rdVal = statVal;
      default:              rdOk  = 1'b0;
    endcase
  end

  // pwm resolution: fixed 13 bits when all clustered
  assign res = allCluster ? 4'hd : displayResBits; // [R08] [R10]
  assign pwmMask = 13'(({1'b0, 13'h1fff}) >> (4'hd - res));
  assign duty[0] = st_q.brt1[15:3]; // [R07]
  assign duty[1] = st_q.brt2;
  assign duty[2] = st_q.brt3;
  assign duty[3] = st_q.brt4;

  // boost period with spread deviation
  assign basePer = lcdbc_pkg::BST_PER[st_q.boost[8:6]];
  assign dev = 16'((32'(basePer) * lcdbc_pkg::SPREAD_PCT) / 100);
  assign effPer = !st_q.ctrl[lcdbc_pkg::CTL_SPREAD] ? basePer :
                  st_q.sprSign ? basePer + dev : basePer - dev; // [R18]
  assign tolLo = basePer - 16'((32'(basePer) *
                 lcdbc_pkg::SYNC_TOL_PCT) / 100);
  assign tolHi = basePer + 16'((32'(basePer) *
                 lcdbc_pkg::SYNC_TOL_PCT) / 100);
  assign syncRise = syncIn & ~st_q.syncPrev;
  // edge must come from a wide pulse and sit in the tolerance band
  assign syncGood = st_q.wOk && st_q.syncP >= tolLo &&
                    st_q.syncP <= tolHi; // [R17]
  // adaptive decisions from display strings only
  assign dispLow     = |(~cluster & headroomLow); // [R12]
  assign dispAllHigh = (|(~cluster)) &&
                       ((~cluster & headroomHigh) == ~cluster); // [R12]

  // next state of the whole block
  always_comb
  begin
    st_d = st_q;
    // nonvolatile defaults taken once after reset release
    if (!st_q.loaded)
    begin
      st_d.loaded = 1'b1;
      st_d.cur1   = nvCurrentDefault; // [R02]
      st_d.range  = nvMaxCurrentRange; // [R02]
    end
    // register writes
    if (st_q.bvalid && axiIn.bready)
      st_d.bvalid = 1'b0;
    if (wrGo)
    begin
      st_d.bvalid = 1'b1;
      st_d.bresp  = 2'b00;
      case (axiIn.awaddr)
        lcdbc_pkg::OFS_CTRL: st_d.ctrl =
          15'((axiIn.wdata & wMask) | ({17'h0, st_q.ctrl} & ~wMask));
        lcdbc_pkg::OFS_BRT1: st_d.brt1 = 16'((axiIn.wdata & wMask) |
          ({16'h0, st_q.brt1} & ~wMask));
        lcdbc_pkg::OFS_BRT2: st_d.brt2 = 13'((axiIn.wdata & wMask) |
          ({19'h0, st_q.brt2} & ~wMask));
        lcdbc_pkg::OFS_BRT3: st_d.brt3 = 13'((axiIn.wdata & wMask) |
          ({19'h0, st_q.brt3} & ~wMask));
        lcdbc_pkg::OFS_BRT4: st_d.brt4 = 13'((axiIn.wdata & wMask) |
          ({19'h0, st_q.brt4} & ~wMask));
        lcdbc_pkg::OFS_CUR1: st_d.cur1 = 12'((axiIn.wdata & wMask) |
          ({20'h0, st_q.cur1} & ~wMask));
        lcdbc_pkg::OFS_CUR2: st_d.cur2 = 8'((axiIn.wdata & wMask) |
          ({24'h0, st_q.cur2} & ~wMask)); // [R05]
        lcdbc_pkg::OFS_CUR3: st_d.cur3 = 8'((axiIn.wdata & wMask) |
          ({24'h0, st_q.cur3} & ~wMask));
        lcdbc_pkg::OFS_CUR4: st_d.cur4 = 8'((axiIn.wdata & wMask) |
          ({24'h0, st_q.cur4} & ~wMask));
        lcdbc_pkg::OFS_TRIM: {st_d.range, st_d.trim} =
          19'((axiIn.wdata & wMask) |
          ({13'h0, st_q.range, st_q.trim} & ~wMask));
        lcdbc_pkg::OFS_BOOST: st_d.boost = 9'((axiIn.wdata & wMask) |
          ({23'h0, st_q.boost} & ~wMask));
        lcdbc_pkg::OFS_STAT: st_d.sticky =
          st_q.sticky & ~5'(axiIn.wdata & wMask); // write one clears
        default: st_d.bresp = 2'b10;
      endcase
    end
    // reads answer one cycle after acceptance
    if (st_q.rvalid && axiIn.rready)
      st_d.rvalid = 1'b0;
    if (rdGo)
    begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = rdVal;
      st_d.rresp  = rdOk ? 2'b00 : 2'b10;
    end
    // sticky flags; setting after clearing so an event is never lost
    st_d.sticky[3:0] = st_d.sticky[3:0] | fltEvt; // [R11] [R14]
    if (inputOvercurrent)
      st_d.sticky[4] = 1'b1; // [R22]
    // trim code to correction, registered per string
    for (int i = 0; i < 4; i++)
      st_d.trimOut[8*i +: 8] =
        lcdbc_pkg::TRIM_CORR[st_q.trim[4*i +: 4]]; // [R01]
    // pwm tick: 20 MHz system clock caps the top code
    if (allCluster)
    begin
      st_d.div = (st_q.div == 2'b00) ?
        (st_q.ctrl[lcdbc_pkg::CTL_RES +: 2] == 2'b00 ? 2'b11 :
         st_q.ctrl[lcdbc_pkg::CTL_RES +: 2] == 2'b01 ? 2'b01 : 2'b00) :
        st_q.div - 2'b01; // [R09]
      if (st_q.div == 2'b00)
        st_d.pwmCnt = (st_q.pwmCnt + 13'h0001) & pwmMask; // [R08]
    end
    else if (displayTick)
      st_d.pwmCnt = (st_q.pwmCnt + 13'h0001) & pwmMask; // [R10]
    // per-string outputs, cluster strings ignore the display path
    for (int i = 0; i < 4; i++)
      st_d.pwmOut[i] = cluster[i] ?
        (st_q.pwmCnt < (duty[i] >> (4'hd - res))) :
        displayPwm[i]; // [R05] [R06] [R23]
    // line switch supervisor
    case (st_q.ls)
      lcdbc_pkg::LS_OFF:
        if (!st_q.ctrl[lcdbc_pkg::CTL_SHDN] && st_q.loaded)
          st_d.ls = lcdbc_pkg::LS_ON;
      lcdbc_pkg::LS_ON:
        if (st_q.ctrl[lcdbc_pkg::CTL_SHDN])
          st_d.ls = lcdbc_pkg::LS_OFF; // [R21]
        else if (anyFault)
          st_d.ls = lcdbc_pkg::LS_RECOVER; // [R21] [R22]
      lcdbc_pkg::LS_RECOVER:
        if (st_q.ctrl[lcdbc_pkg::CTL_SHDN])
          st_d.ls = lcdbc_pkg::LS_OFF;
        else if (!anyFault && st_q.sticky == 5'h00)
          st_d.ls = lcdbc_pkg::LS_ON; // leave once software cleared
      default:
        st_d.ls = lcdbc_pkg::LS_OFF;
    endcase
    // boost target: ramp to start, then adapt or hold
    if (st_q.ls != lcdbc_pkg::LS_ON)
    begin
      st_d.target   = 8'h00;
      st_d.rampDone = 1'b0;
      st_d.adaptCnt = 8'h00;
    end
    else
    begin
      st_d.adaptCnt = (st_q.adaptCnt == 8'(lcdbc_pkg::ADAPT_CYC - 1)) ?
                      8'h00 : st_q.adaptCnt + 8'h01;
      if (!st_q.rampDone)
      begin
        if (st_q.adaptCnt == 8'h00)
        begin
          if (st_q.target < startTgt)
            st_d.target = st_q.target + 8'h01; // [R16]
          else
            st_d.rampDone = 1'b1;
        end
      end
      else if (allCluster || !st_q.ctrl[lcdbc_pkg::CTL_ADAP])
        st_d.target = startTgt; // [R13]
      else if (st_q.adaptCnt == 8'h00)
      begin
        if (dispLow && st_q.target != 8'hff)
          st_d.target = st_q.target + 8'h01; // [R16]
        else if (dispAllHigh && st_q.target != 8'h00)
          st_d.target = st_q.target - 8'h01;
      end
    end
    // sync measurement
    st_d.syncPrev = syncIn;
    if (syncIn)
      st_d.syncW = (st_q.syncW == 16'hffff) ? 16'hffff :
                   st_q.syncW + 16'h0001;
    else
      st_d.syncW = 16'h0000;
    if (st_q.syncPrev && !syncIn)
      st_d.wOk = st_q.syncW >= 16'(lcdbc_pkg::SYNC_MIN_CYC); // [R17]
    if (syncRise)
    begin
      st_d.syncP    = 16'h0001;
      st_d.syncLock = syncGood;
      st_d.wOk      = 1'b0;
    end
    else
    begin
      st_d.syncP = (st_q.syncP == 16'hffff) ? 16'hffff :
                   st_q.syncP + 16'h0001;
      if (st_q.syncP > tolHi)
        st_d.syncLock = 1'b0; // sync lost, fall back [R17]
    end
    // boost switching tick from sync or internal counter
    st_d.bstTick = 1'b0;
    if (st_q.syncLock && syncRise && syncGood)
    begin
      st_d.bstTick = 1'b1; // [R17]
      st_d.bstCnt  = 16'h0000;
    end
    else if (st_q.bstCnt + 16'h0001 >= effPer)
    begin
      st_d.bstCnt  = 16'h0000;
      st_d.bstTick = !st_q.syncLock;
    end
    else
      st_d.bstCnt = st_q.bstCnt + 16'h0001;
    // spread modulation sign toggles each half modulation period
    if (st_q.sprCnt == 16'(SPREAD_HALF_CYC - 1))
    begin
      st_d.sprCnt  = 16'h0000;
      st_d.sprSign = ~st_q.sprSign; // [R18]
    end
    else
      st_d.sprCnt = st_q.sprCnt + 16'h0001;
    // pump clock only once the gate supply select is set
    if (st_q.ctrl[lcdbc_pkg::CTL_PUMPON] && st_q.ctrl[lcdbc_pkg::CTL_GDSEL])
    begin
      if (st_q.pumpCnt + 8'h01 >= lcdbc_pkg::PUMP_HALF[
          st_q.ctrl[lcdbc_pkg::CTL_PUMPCLK +: 2]])
      begin
        st_d.pumpCnt = 8'h00;
        st_d.pumpClk = ~st_q.pumpClk; // [R19] [R20]
      end
      else
        st_d.pumpCnt = st_q.pumpCnt + 8'h01;
    end
    else
    begin
      st_d.pumpCnt = 8'h00;
      st_d.pumpClk = 1'b0;
    end
  end

  // all state in one register; reset clears levels 2 and 3
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      st_q <= lcdbc_pkg::ST_RST; // [R03]
    else
      st_q <= st_d;
  end

  assign pwmOut                = st_q.pwmOut;
  assign trimCorrection        = st_q.trimOut;
  assign stringOneCurrentLevel = st_q.cur1;
  assign stringCurrentLevels   = {st_q.cur4, st_q.cur3, st_q.cur2};
  assign maxCurrentRange       = st_q.range;
  assign derateEnable          = ~cluster; // [R15]
  assign boostTarget           = st_q.target;
  assign boostTick             = st_q.bstTick;
  assign pumpClk               = st_q.pumpClk;
  assign lineSwitchOn          = st_q.ls == lcdbc_pkg::LS_ON; // [R21]
  assign nchannelLineSwitch    = st_q.ctrl[lcdbc_pkg::CTL_NCH];

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_trim_mid: assert property (st_q.trim[3:0] == 4'h7 |=> // [R01]
    st_q.trimOut[7:0] == 8'h00) else $error("trim code 7 not zero");
  a_nv_load: assert property ($rose(st_q.loaded) |-> // [R02]
    st_q.cur1 == $past(nvCurrentDefault)) else $error("nv load missed");
  a_reset_levels: assert property (!st_q.loaded |-> // [R03]
    st_q.cur2 == 8'h00 && st_q.cur3 == 8'h00) else $error("levels not 0");
  a_zero_duty: assert property (cluster[1] && st_q.brt2 == 13'h0000 |=>
    !st_q.pwmOut[1]) else $error("zero duty drove high"); // [R23]
  a_pin_ignored: assert property (cluster[2] && displayPwm[2] && // [R06]
    st_q.brt3 == 13'h0000 |=> !st_q.pwmOut[2]) else $error("pin leaked");
  a_full_duty: assert property (allCluster && st_q.brt4 == 13'h1fff && // [R08]
    st_q.pwmCnt != 13'h1fff |=> st_q.pwmOut[3]) else $error("duty short");
  a_fault_gate: assert property (!fltEn && st_q.sticky[3:0] == 4'h0 && // [R14]
    !wrGo |=> st_q.sticky[3:0] == 4'h0) else $error("fault not gated");
  a_fault_set: assert property (fltEn && cluster[2] && headroomLow[2] |=>
    st_q.sticky[2]) else $error("headroom fault lost"); // [R11]
  a_hold_start: assert property (allCluster && st_q.rampDone && // [R13]
    st_q.ls == lcdbc_pkg::LS_ON ##1 st_q.ls == lcdbc_pkg::LS_ON |->
    st_q.target == $past(startTgt)) else $error("target not held");
  a_line_off: assert property (st_q.ls == lcdbc_pkg::LS_ON && // [R21]
    anyFault && !st_q.ctrl[lcdbc_pkg::CTL_SHDN] |=> !lineSwitchOn
    ##1 1'b1) else $error("switch stayed on");
  a_ocp_flag: assert property (inputOvercurrent |=> st_q.sticky[4]) // [R22]
    else $error("overcurrent flag missed");
  a_pump_gate: assert property (!st_q.ctrl[lcdbc_pkg::CTL_GDSEL] |=> // [R19]
    !pumpClk) else $error("pump ran without gate select");
endmodule // lcdbc_top

// ===== test/lcdbc_host_model.sv
// host model: axi4-lite master feeding the control block
`timescale 1ns/1ps
module lcdbc_host_model (
  input  wire logic                      clock,
  input  wire lcdbc_pkg::lcdbc_axi_out_t axiOut,
  output lcdbc_pkg::lcdbc_axi_in_t       axiIn
);
  initial axiIn = '0;
  // address and data offered together, released once taken
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] w;
    w = d;
    // a lit string never gets a zero current
    if (a >= lcdbc_pkg::OFS_CUR1 && a <= lcdbc_pkg::OFS_CUR4 && d == 0)
      return;
    // gate-drive select rides along with pump enable
    if (a == lcdbc_pkg::OFS_CTRL && d[lcdbc_pkg::CTL_PUMPON])
      w[lcdbc_pkg::CTL_GDSEL] = 1'b1;
    @(posedge clock);
    axiIn <= '{1'b1, a, 1'b1, w, 4'hf, 1'b1, 1'b0, 8'h00, 1'b0};
    do @(negedge clock); while (axiOut.awready !== 1'b1);
    @(posedge clock);
    axiIn.awvalid <= 1'b0;
    axiIn.wvalid <= 1'b0;
    axiIn.awaddr <= ~a; // released lines never keep the old value
    axiIn.wdata <= ~w;
    do @(negedge clock); while (axiOut.bvalid !== 1'b1);
    @(posedge clock);
    axiIn.bready <= 1'b0;
  endtask
  // single read, rready held until the answer
  task automatic read(input logic [7:0] a);
    @(posedge clock);
    axiIn.arvalid <= 1'b1;
    axiIn.araddr <= a;
    axiIn.rready <= 1'b1;
    do @(negedge clock); while (axiOut.arready !== 1'b1);
    @(posedge clock);
    axiIn.arvalid <= 1'b0;
    axiIn.araddr <= ~a;
    do @(negedge clock); while (axiOut.rvalid !== 1'b1);
    @(posedge clock);
    axiIn.rready <= 1'b0;
  endtask
endmodule // lcdbc_host_model

// ===== test/lcdbc_top_test.sv
// self-checking bench for the led cluster control block
`timescale 1ns/1ps
module lcdbc_top_test;
  logic                      clock = 1'b0;
  logic                      rst = 1'b1;
  lcdbc_pkg::lcdbc_axi_in_t  axiIn;
  lcdbc_pkg::lcdbc_axi_out_t axiOut;
  logic [3:0]  displayPwm = 4'h0, headroomHigh = 4'h0, headroomLow = 4'h0;
  logic        inputOvercurrent = 1'b0;
  logic [11:0] nvCur = 12'h000, curOne;
  logic [2:0]  nvRange = 3'h0, maxRange;
  logic [3:0]  pwmOut, derate;
  logic [31:0] trimOut, expQ [$], maskQ [$];
  logic [23:0] curRest;
  logic [7:0]  target;
  logic        lineOn, nchOn;
  logic        syncIn = 1'b0, syncOn = 1'b0, tick, pumpClk;
  logic [1:0]  respQ [$];
  logic [12:0] br [4];
  logic [15:0] brOne;
  logic [3:0]  k;
  int n_errors = 0, n_checks = 0, cycles = 0, nb, np;
  integer seed = 32'hb1dcaf78;
  int corr [16] = '{65, 56, 47, 37, 28, 19, 9, 0,
                    -9, -19, -28, -37, -47, -56, -65, -74};
  lcdbc_top #(.SPREAD_HALF_CYC(16)) dut (.clock(clock), .rst(rst),
    .axiIn(axiIn), .axiOut(axiOut), .nvCurrentDefault(nvCur),
    .nvMaxCurrentRange(nvRange), .displayPwm(displayPwm),
    .displayTick(1'b0), .displayResBits(4'hd), .headroomHigh(headroomHigh),
    .headroomLow(headroomLow), .inputOvercurrent(inputOvercurrent),
    .otherFault(1'b0), .syncIn(syncIn), .pwmOut(pwmOut),
    .trimCorrection(trimOut), .stringOneCurrentLevel(curOne),
    .stringCurrentLevels(curRest), .maxCurrentRange(maxRange),
    .derateEnable(derate), .boostTarget(target), .boostTick(tick),
    .pumpClk(pumpClk), .lineSwitchOn(lineOn), .nchannelLineSwitch(nchOn));
  lcdbc_host_model host (.clock(clock), .axiOut(axiOut), .axiIn(axiIn));
  initial forever #25 clock = ~clock;
  // noise on pins that cluster strings ignore while detection is off; also caps the run
  always @(posedge clock)
  begin
    {displayPwm, headroomHigh, headroomLow} <= 12'($random(seed));
    syncIn <= syncOn && cycles % 180 < 5; // 250 ns pulses
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // note the expected word, then let the host fetch it
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                    input logic [1:0] r);
    expQ.push_back(e);
    maskQ.push_back(m);
    respQ.push_back(r);
    host.read(a);
  endtask
  // a few cycles to settle, then count high cycles over one period
  task automatic pwm_window(input int mul);
    int cnt [4] = '{0, 0, 0, 0};
    repeat (8) @(posedge clock);
    repeat (8192 * mul)
    begin
      @(negedge clock);
      for (int i = 0; i < 4; i++) cnt[i] += int'(pwmOut[i]);
    end
    for (int i = 0; i < 4; i++)
      check(32'(cnt[i]), 32'(br[i]) * mul);
  endtask
  // high cycles of boost tick and pump clock over n cycles
  task automatic count_hi(input int n, output int bt, output int pc);
    bt = 0;
    pc = 0;
    repeat (n)
    begin
      @(negedge clock);
      bt += int'(tick);
      pc += int'(pumpClk);
    end
  endtask
  always @(negedge clock)
    if (axiOut.rvalid === 1'b1 && axiIn.rready === 1'b1)
    begin
      check(axiOut.rdata & maskQ.pop_front(), expQ.pop_front());
      check(32'(axiOut.rresp), 32'(respQ.pop_front()));
    end
  initial
  begin
    nvCur = 12'($random(seed));
    nvRange = 3'($random(seed));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(negedge clock);
    check(32'(curOne), 32'(nvCur));
    check(32'(maxRange), 32'(nvRange));
    check(32'(curRest), 32'h0);
    check(trimOut, 32'h0);
    rd(lcdbc_pkg::OFS_TRIM, {13'h0, nvRange, 16'h7777}, '1, 2'b00);
    for (int c = 0; c < 16; c++)
    begin
      k = 4'(c);
      host.write(lcdbc_pkg::OFS_TRIM, {13'h0, nvRange, k + 4'd3, k + 4'd2,
                 k + 4'd1, k});
      repeat (2) @(negedge clock);
      check(trimOut, {8'(corr[k + 4'd3]), 8'(corr[k + 4'd2]),
            8'(corr[k + 4'd1]), 8'(corr[k])});
    end
    host.write(lcdbc_pkg::OFS_CUR2, 32'h3c);
    brOne = 16'($random(seed));
    host.write(lcdbc_pkg::OFS_BRT1, 32'(brOne));
    br[0] = brOne[15:3];
    for (int i = 1; i < 4; i++)
    begin
      // two and three dark, four full: drives the duty assertions
      br[i] = (i == 3) ? 13'h1fff : 13'h0000;
      host.write(lcdbc_pkg::OFS_BRT1 + 8'(4 * i), 32'(br[i]));
    end
    // frequency codes 11 down to 00; 01 and 00 slow the count 2x and 4x
    for (int f = 3; f >= 0; f--)
    begin
      host.write(lcdbc_pkg::OFS_CTRL, 32'h0f | (32'(f) << 9));
      pwm_window(f > 1 ? 1 : 4 >> f);
    end
    check(32'(derate), 32'h0);
    check(32'(curRest[7:0]), 32'h3c);
    check(32'(target), 32'h80);
    rd(lcdbc_pkg::OFS_STAT, 32'h8000, 32'hff0f, 2'b00);
    rd(8'h40, 32'h0, '1, 2'b10);
    check(32'(lineOn), 32'h1);
    @(posedge clock);
    inputOvercurrent <= 1'b1;
    repeat (2) @(negedge clock);
    check(32'(lineOn), 32'h0);
    @(posedge clock);
    inputOvercurrent <= 1'b0;
    rd(lcdbc_pkg::OFS_STAT, 32'h50, 32'h50, 2'b00);
    host.write(lcdbc_pkg::OFS_STAT, 32'h1f);
    repeat (3) @(negedge clock);
    check(32'(lineOn), 32'h1);
    // pump code 11; 600 cycles span whole boost and pump periods
    host.write(lcdbc_pkg::OFS_CTRL, 32'h190f);
    count_hi(600, nb, np);
    check(nb, 32'd3);
    check(np, 32'd300);
    // sync every 180 cycles locks within three pulses, then drops
    syncOn <= 1'b1;
    repeat (720) @(negedge clock);
    count_hi(1800, nb, np);
    check(nb, 32'd10);
    syncOn <= 1'b0;
    repeat (300) @(negedge clock);
    count_hi(600, nb, np);
    check(nb, 32'd3);
    host.write(lcdbc_pkg::OFS_CTRL, 32'h620f);
    repeat (3) @(negedge clock);
    check(32'(lineOn), 32'h0);
    check(32'(nchOn), 32'h1);
    // detection on: noisy headroom must latch all four strings
    host.write(lcdbc_pkg::OFS_CTRL, 32'h621f);
    repeat (20) @(negedge clock);
    rd(lcdbc_pkg::OFS_STAT, 32'h0f, 32'h0f, 2'b00);
    check(32'(expQ.size()), 32'h0);
    print_verdict();
  end
endmodule // lcdbc_top_test
